/* File: core/mpd_decoder.sv */
// module: decodes motor parameter fields and classes start condition
`timescale 1ns/10ps
module mpd_decoder
(
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic                       res_wr,
  input  wire logic [mpd_pkg::CODE_W-1:0] phase_resistance_code,
  input  wire logic                       bemf_wr,
  input  wire logic [mpd_pkg::CODE_W-1:0] bemf_constant_code,
  input  wire mpd_pkg::mpd_sense_s        sense,
  output mpd_pkg::mpd_out_s               dec,
  output mpd_pkg::mpd_cond_e              cond,
  output logic                            cond_valid
);
  import mpd_pkg::*;

  // slots of the per-field arrays
  localparam int NUM_FIELDS = 2;
  localparam int RES_IDX    = 0;
  localparam int BEMF_IDX   = 1;

  // one shifter stage per exponent bit
  localparam int NUM_STAGES = EXP_W;

  // mantissa widened to the result width
  function automatic logic [LIN_W-1:0] widen_mant
  (
    input logic [CODE_W-1:0] code
  );
  begin
    widen_mant = {{(LIN_W-MANT_W){1'b0}}, code[MANT_LSB +: MANT_W]};
  end
  endfunction

  // exponent field of a code
  function automatic logic [EXP_W-1:0] code_exp
  (
    input logic [CODE_W-1:0] code
  );
  begin
    code_exp = code[EXP_LSB +: EXP_W];
  end
  endfunction

  // decoded resistance under the supported floor
  function automatic logic below_floor
  (
    input logic [LIN_W-1:0] lin
  );
  begin
    below_floor = (lin < LIN_W'(RES_MIN_LIN));
  end
  endfunction

  // start condition from the sense bits
  function automatic mpd_cond_e classify
  (
    input logic moving,
    input logic reverse
  );
  begin
    case ({moving, reverse})
      2'b00:   classify = MPD_STILL;   // see (R9)
      2'b01:   classify = MPD_STILL;   // see (R9)
      2'b10:   classify = MPD_FORWARD; // see (R9)
      2'b11:   classify = MPD_REVERSE; // see (R9)
      default: classify = MPD_STILL;
    endcase
  end
  endfunction

  // per-field strobes, codes and results
  wire logic              field_wr   [NUM_FIELDS];
  wire logic [CODE_W-1:0] field_code [NUM_FIELDS];
  wire logic [LIN_W-1:0]  field_next [NUM_FIELDS];
  wire logic [LIN_W-1:0]  field_lin  [NUM_FIELDS];

  // resistance floor flag register
  logic                   res_low;

  assign field_wr[RES_IDX]    = res_wr;
  assign field_wr[BEMF_IDX]   = bemf_wr;
  assign field_code[RES_IDX]  = phase_resistance_code;
  assign field_code[BEMF_IDX] = bemf_constant_code;

  // one mantissa-and-shift decoder per field
  generate
    for (genvar g = 0; g < NUM_FIELDS; g++)
    begin : gen_decode
      wire logic [LIN_W-1:0] stage [NUM_STAGES+1];
      wire logic [EXP_W-1:0] shift;

      assign shift    = code_exp(field_code[g]);
      assign stage[0] = widen_mant(field_code[g]); // see (R2) (R6)

      // stage k moves the value left by two to the k
      for (genvar k = 0; k < NUM_STAGES; k++)
      begin : gen_stage
        assign stage[k+1] = shift[k] ? (stage[k] << (1 << k))
                                     : stage[k];
      end

      // all-ones code reaches the largest value
      assign field_next[g] = stage[NUM_STAGES]; // see (R3) (R7) (R8)
    end
  endgenerate

  // result registers, each standing until its field is written again
  generate
    for (genvar g = 0; g < NUM_FIELDS; g++)
    begin : gen_result
      logic [LIN_W-1:0] lin_q;

      always_ff @(posedge clk_sys)
      begin
        if (!resetn)
        begin
          lin_q <= LIN_RST;
        end
        else if (field_wr[g])
        begin
          lin_q <= field_next[g]; // see (R11)
        end
      end

      assign field_lin[g] = lin_q;
    end
  endgenerate

  // resistance floor flag, refreshed on each resistance write
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      res_low <= FLAG_RST;
    end
    else if (field_wr[RES_IDX])
    begin
      res_low <= below_floor(field_next[RES_IDX]); // see (R4)
    end
  end

  // start condition, taken on each valid sense cycle
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      cond <= COND_RST;
    end
    else if (sense.valid)
    begin
      cond <= classify(sense.moving, sense.reverse); // see (R9)
    end
  end

  // one valid pulse per valid sense cycle
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      cond_valid <= VALID_RST;
    end
    else
    begin
      cond_valid <= sense.valid; // see (R9)
    end
  end

  // result carrier in field order
  assign dec = {field_lin[RES_IDX],  // see (R1)
                field_lin[BEMF_IDX], // see (R5)
                res_low};

endmodule

/* File: core/mpd_pkg.sv */
// package: constants and carriers of the motor parameter decoder
//
// Contract
// (R1) resistance field is 7 bits; decoded lsb weighs 7.35 milliohm.
// (R2) resistance decodes as low four bits shifted left by upper three.
// (R3) all-ones resistance code decodes to 1920, about 14.1 ohm.
// (R4) software keeps decoded resistance at or above 4, about 0.0294 ohm.
// (R5) decoded back-emf value is measured constant times weighting 1442.
// (R6) back-emf field is 7 bits, decoded like the resistance field.
// (R7) all-ones back-emf code decodes to 1920, about 1330 mV/Hz.
// (R8) back-emf code one decodes to one, about 0.7 mV/Hz.
// (R9) motor is classed as stationary, forward or reverse before start.
// (R10) software writes resistance and back-emf fields before driving.
// (R11) each field gives an 11-bit unsigned result, updated on write.
package mpd_pkg;

  localparam int CODE_W        = 7;
  localparam int MANT_W        = 4;
  localparam int EXP_W         = 3;
  localparam int LIN_W         = 11;
  localparam int MANT_LSB      = 0;
  localparam int EXP_LSB       = 4;
  localparam int RES_LSB_UOHM  = 7350;
  localparam int BEMF_WEIGHT   = 1442;
  localparam int RES_MIN_LIN   = 4;
  localparam logic [CODE_W-1:0] CODE_RST = 7'h00;
  localparam logic [LIN_W-1:0]  LIN_RST  = 11'h000;
  localparam logic              FLAG_RST  = 1'b1;
  localparam logic              VALID_RST = 1'b0;

  typedef enum logic [1:0]
  {
    MPD_STILL   = 2'b00,
    MPD_FORWARD = 2'b01,
    MPD_REVERSE = 2'b11
  } mpd_cond_e;

  localparam mpd_cond_e COND_RST = MPD_STILL;

  typedef struct packed
  {
    logic [LIN_W-1:0] phase_to_center_resistance;
    logic [LIN_W-1:0] bemf_constant_linear;
    logic             res_below_min;
  } mpd_out_s;

  typedef struct packed
  {
    logic       valid;
    logic       moving;
    logic       reverse;
  } mpd_sense_s;

endpackage

/* File: verification/mpd_properties.sv */
// checker: port properties of the parameter decoder
`timescale 1ns/10ps
module mpd_properties import mpd_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       res_wr,
  input wire logic [6:0] phase_resistance_code,
  input wire logic       bemf_wr,
  input wire logic [6:0] bemf_constant_code,
  input wire mpd_sense_s sense,
  input wire mpd_out_s   dec,
  input wire mpd_cond_e  cond,
  input wire logic       cond_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire [6:0] p = phase_resistance_code, q = bemf_constant_code;
  wire [10:0] r = dec[22:12], b = dec[11:1];
  wire [10:0] dp = {7'h0, p[3:0]} << p[6:4], db = {7'h0, q[3:0]} << q[6:4];
  wire [1:0] ce = {sense.moving & sense.reverse, sense.moving};
  wire lo = dp < 11'(RES_MIN_LIN);
  a_res_dec: assert property (res_wr |=> r == $past(dp))
    else $error("res decode");
  a_bemf_dec: assert property (bemf_wr |=> b == $past(db))
    else $error("bemf decode");
  a_res_hold: assert property (!res_wr |=> $stable(r))
    else $error("res hold");
  a_bemf_hold: assert property (!bemf_wr |=> $stable(b))
    else $error("bemf hold");
  a_res_floor: assert property (res_wr |=> dec[0] == $past(lo))
    else $error("res floor");
  a_res_max: assert property (res_wr && p == 7'h7f
    |=> r == 11'h780) else $error("res max");
  a_bemf_max: assert property (bemf_wr && q == 7'h7f
    |=> b == 11'h780) else $error("bemf max");
  a_bemf_one: assert property (bemf_wr && q == 7'h01
    |=> b == 11'h001) else $error("bemf one");
  a_cond_class: assert property (sense.valid |=> cond == $past(ce))
    else $error("cond class");
  a_cond_hold: assert property (!sense.valid |=> $stable(cond))
    else $error("cond hold");
  a_cond_pulse: assert property (sense.valid |=> cond_valid)
    else $error("cond valid");
  a_valid_drop: assert property (!sense.valid |=> !cond_valid)
    else $error("cond valid drop");
endmodule
bind mpd_decoder mpd_properties i_chk (.*);

/* File: verification/motor_param_decoder_bench.sv */
// bench: scenarios for the parameter decoder
`timescale 1ns/10ps
module motor_param_decoder_bench;
  import mpd_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, res_wr = 1'b0, bemf_wr = 1'b0;
  logic [6:0] rc = 7'h00, bc = 7'h00;
  // resistance codes keep the decoded value at or above the floor
  logic [6:0] rt [5] = '{7'h04, 7'h1f, 7'h28, 7'h58, 7'h7f};
  logic [10:0] re [5] = '{11'h004, 11'h01e, 11'h020, 11'h100, 11'h780};
  logic [6:0] bt [5] = '{7'h01, 7'h03, 7'h04, 7'h28, 7'h7f};
  logic [10:0] be [5] = '{11'h001, 11'h003, 11'h004, 11'h020, 11'h780};
  mpd_cond_e ce [4] = '{MPD_STILL, MPD_STILL, MPD_FORWARD, MPD_REVERSE};
  mpd_sense_s sense = 3'h0;
  mpd_out_s dec;
  mpd_cond_e cond;
  logic cond_valid;
  int errors = 0, cmp_count = 0;
  always #4 clk_sys = ~clk_sys;
  mpd_decoder i_dut (.clk_sys, .resetn, .res_wr, .phase_resistance_code(rc),
    .bemf_wr, .bemf_constant_code(bc), .sense, .dec, .cond, .cond_valid);
  task chk(string n, logic [10:0] x, logic [10:0] g);
    cmp_count++;
    errors += int'(g !== x);
    if (g !== x) $display("[FAIL] %s exp %h got %h", n, x, g);
  endtask
  task close_out;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task t_reset;
    #1 chk("rst res", 11'h000, dec[22:12]);
    chk("rst bemf", 11'h000, dec[11:1]);
    chk("rst low", 11'h001, dec[0]);
    chk("rst cond", MPD_STILL, cond);
    chk("rst valid", 11'h000, cond_valid);
  endtask
  task t_codes;
    foreach (rt[i])
    begin
      @(posedge clk_sys);
      {res_wr, bemf_wr, rc, bc} <= {2'h3, rt[i], bt[4-i]};
      @(posedge clk_sys);
      {res_wr, bemf_wr, rc, bc} <= {2'h0, ~rt[i], ~bt[4-i]};
      #1 chk("res", re[i], dec[22:12]);
      chk("bemf", be[4-i], dec[11:1]);
      chk("low", 11'h000, dec[0]);
      @(posedge clk_sys);
      #1 chk("res hold", re[i], dec[22:12]);
      chk("bemf hold", be[4-i], dec[11:1]);
    end
  endtask
  task t_cond;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      sense <= {1'b1, 2'(i)};
      @(posedge clk_sys);
      sense <= {1'b0, ~2'(i)};
      #1 chk("cond", ce[i], cond);
      chk("valid", 11'h001, cond_valid);
      @(posedge clk_sys);
      #1 chk("cond hold", ce[i], cond);
      chk("valid drop", 11'h000, cond_valid);
    end
  endtask
  task t_reset_mid;
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    @(posedge clk_sys);
    {res_wr, rc} <= {1'b1, rt[0]};
    @(posedge clk_sys);
    res_wr <= 1'b0;
    #1 chk("res again", re[0], dec[22:12]);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_codes();
    t_cond();
    t_reset_mid();
    close_out();
  end
endmodule
